// file: rtl/aet_defs.svh
// register indices, field positions, reset values and timing counts of the timer
`ifndef AET_DEFS_SVH
`define AET_DEFS_SVH
`define AET_IDX_IRQ_FLAGS 8'h37
`define AET_IDX_IRQ_MASK 8'h70
`define AET_IDX_CONTROL_A 8'hB0
`define AET_IDX_CONTROL_B 8'hB1
`define AET_IDX_COUNT 8'hB2
`define AET_IDX_COMPARE_A 8'hB3
`define AET_IDX_COMPARE_B 8'hB4
`define AET_IDX_ASYNC_STATUS 8'hB6
`define AET_IDX_SPECIAL_FUNC 8'hB7
`define AET_RESET_VALUE 8'h00
`define AET_COM_A_MSB 7
`define AET_COM_A_LSB 6
`define AET_COM_B_MSB 5
`define AET_COM_B_LSB 4
`define AET_WGM_LOW_MSB 1
`define AET_WGM_HIGH_BIT 3
`define AET_FORCE_A_BIT 7
`define AET_FORCE_B_BIT 6
`define AET_CS_MSB 2
`define AET_ASYNC_SELECT_BIT 5
`define AET_PRESCALER_RESET_BIT 0
`define AET_BUSY_CONTROL_B 0
`define AET_BUSY_CONTROL_A 1
`define AET_BUSY_COMPARE_B 2
`define AET_BUSY_COMPARE_A 3
`define AET_BUSY_COUNT 4
`define AET_HOLD_COUNT 5
`define AET_FLAG_SYNC_CYCLES 3
`define AET_WGM_CTC 3'h2
`define AET_COUNT_MAX 8'hFF
`define AET_OSC_SETTLE_MS 1000
`endif

// file: rtl/aet_pkg.sv
// types shared by the asynchronous eight-bit timer
package aet_pkg;
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] wgm;
    logic [2:0] cs;
  } aet_ctrl_type;
  typedef struct packed {
    logic match_b;
    logic match_a;
    logic overflow;
  } aet_event_type;
endpackage : aet_pkg

// file: rtl/aet_timer.sv
// asynchronous eight-bit timer/counter with APB register access
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "aet_defs.svh"
// Function
// - async writes park in holding stage, move after two external clock edges
// - each async register owns an independent holding stage
// - async status shows an update-busy bit per holding stage
// - interrupt logic needs one external clock period to reset
// - oscillator kept enabled in async mode except power-down sleep
// - wake begins on timer clock after the interrupt condition
// - readable count refreshed on each external clock rising edge
// - async flag sync takes three system clocks plus one timer period
// - compare outputs change on compare matches at timer ticks or on force strobes from control B
// - prescaler input is system clock, or external pin when async selected
// - counter clock undivided, divided by 8..1024, or stopped
// - clock select 0 stop, 1 direct, 2..7 divide 8,32,64,128,256,1024
// - prescaler reset bit restarts prescaler phase
// - register map at documented offsets, all reset to zero
// - compare mode fields in control A bits 7:6 and 5:4 drive pins
module aet_timer
  import aet_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_osc_in,
  input wire logic power_down_sleep,
  output logic osc_enable,
  output logic compare_output_a,
  output logic compare_output_a_oe,
  output logic compare_output_b,
  output logic compare_output_b_oe,
  output logic irq_request
);

  function automatic logic div_tick(input logic [2:0] cs, input logic [9:0] psc,
                                    input logic in_tick);
    logic [9:0] m;
    m = 10'h000;
    case (cs)
      3'h2: m = 10'h007;
      3'h3: m = 10'h01F;
      3'h4: m = 10'h03F;
      3'h5: m = 10'h07F;
      3'h6: m = 10'h0FF;
      3'h7: m = 10'h3FF;
      default: m = 10'h000;
    endcase
    if (cs == 3'h0) begin
      div_tick = 1'b0;
    end else begin
      div_tick = in_tick && ((psc & m) == m);
    end
  endfunction : div_tick

  function automatic logic wave_next(input logic [1:0] com, input logic cur);
    case (com)
      2'h1: wave_next = ~cur;
      2'h2: wave_next = 1'b0;
      2'h3: wave_next = 1'b1;
      default: wave_next = cur;
    endcase
  endfunction : wave_next

  logic osc_meta_reg, osc_sync_reg, osc_prev_reg;
  logic [7:0] control_a_reg, control_b_reg, count_reg, compare_a_reg, compare_b_reg;
  logic [7:0] count_view_reg, irq_flags_reg, irq_mask_reg;
  logic async_select_reg, block_match_reg, psc_clear_reg, force_a_reg, force_b_reg;
  logic [9:0] psc_reg;
  logic [7:0] hold_reg [`AET_HOLD_COUNT];
  logic [`AET_HOLD_COUNT-1:0] busy_reg, edge_seen_reg, apply;
  logic [7:0] apply_data [`AET_HOLD_COUNT];
  aet_event_type pend_reg, pipe0_reg, pipe1_reg, pipe2_reg, evt;
  aet_ctrl_type ctrl;
  logic ext_tick, in_tick, cnt_tick, wr_en, rd_setup, match_a, match_b;
  logic [7:0] idx, wbyte, top, rdata;
  logic [`AET_HOLD_COUNT-1:0] wr_hit;
  logic [2:0] flag_set;

  // pin passes two flops before edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_meta_reg <= ext_osc_in;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end
  assign ext_tick = osc_sync_reg & ~osc_prev_reg;

  assign idx = paddr[9:2];
  assign wbyte = pwdata[7:0];
  // refused accesses must not land; pslverr stands with pready
  assign wr_en = psel & penable & pwrite & pready & ~pslverr;
  assign rd_setup = psel & ~penable;
  assign wr_hit[`AET_BUSY_CONTROL_B] = wr_en && idx == `AET_IDX_CONTROL_B;
  assign wr_hit[`AET_BUSY_CONTROL_A] = wr_en && idx == `AET_IDX_CONTROL_A;
  assign wr_hit[`AET_BUSY_COMPARE_B] = wr_en && idx == `AET_IDX_COMPARE_B;
  assign wr_hit[`AET_BUSY_COMPARE_A] = wr_en && idx == `AET_IDX_COMPARE_A;
  assign wr_hit[`AET_BUSY_COUNT] = wr_en && idx == `AET_IDX_COUNT;

  // mode bits split over two registers
  assign ctrl.com_a = control_a_reg[`AET_COM_A_MSB:`AET_COM_A_LSB];
  assign ctrl.com_b = control_a_reg[`AET_COM_B_MSB:`AET_COM_B_LSB];
  assign ctrl.wgm = {control_b_reg[`AET_WGM_HIGH_BIT], control_a_reg[`AET_WGM_LOW_MSB:0]};
  assign ctrl.cs = control_b_reg[`AET_CS_MSB:0];

  // busy set on write, cleared on transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= '0;
      edge_seen_reg <= '0;
      for (int i = 0; i < `AET_HOLD_COUNT; i++) begin
        hold_reg[i] <= `AET_RESET_VALUE;
      end
    end else begin
      for (int i = 0; i < `AET_HOLD_COUNT; i++) begin
        if (wr_hit[i] && async_select_reg) begin
          // rewrite while busy restarts the transfer
          hold_reg[i] <= wbyte;
          busy_reg[i] <= 1'b1;
          edge_seen_reg[i] <= 1'b0;
        end else if (busy_reg[i] && ext_tick) begin
          edge_seen_reg[i] <= ~edge_seen_reg[i];
          busy_reg[i] <= ~edge_seen_reg[i];
        end
      end
    end
  end

  // transfer on second external rising edge
  always_comb begin
    for (int i = 0; i < `AET_HOLD_COUNT; i++) begin
      if (async_select_reg) begin
        apply[i] = busy_reg[i] && ext_tick && edge_seen_reg[i] && !wr_hit[i];
        apply_data[i] = hold_reg[i];
      end else begin
        apply[i] = wr_hit[i];
        apply_data[i] = wbyte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_a_reg <= `AET_RESET_VALUE;
      control_b_reg <= `AET_RESET_VALUE;
      compare_a_reg <= `AET_RESET_VALUE;
      compare_b_reg <= `AET_RESET_VALUE;
      force_a_reg <= 1'b0;
      force_b_reg <= 1'b0;
    end else begin
      force_a_reg <= 1'b0;
      force_b_reg <= 1'b0;
      if (apply[`AET_BUSY_CONTROL_A]) begin
        // reserved bits 3:2 stay zero
        control_a_reg <= apply_data[`AET_BUSY_CONTROL_A] & 8'hF3;
      end
      if (apply[`AET_BUSY_CONTROL_B]) begin
        // force bits are strobes, never stored
        control_b_reg <= apply_data[`AET_BUSY_CONTROL_B] & 8'h0F;
        force_a_reg <= apply_data[`AET_BUSY_CONTROL_B][`AET_FORCE_A_BIT];
        force_b_reg <= apply_data[`AET_BUSY_CONTROL_B][`AET_FORCE_B_BIT];
      end
      if (apply[`AET_BUSY_COMPARE_A]) begin
        compare_a_reg <= apply_data[`AET_BUSY_COMPARE_A];
      end
      if (apply[`AET_BUSY_COMPARE_B]) begin
        compare_b_reg <= apply_data[`AET_BUSY_COMPARE_B];
      end
    end
  end

  assign in_tick = async_select_reg ? ext_tick : 1'b1;
  assign cnt_tick = div_tick(ctrl.cs, psc_reg, in_tick);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_reg <= 10'h000;
    end else if (psc_clear_reg) begin
      psc_reg <= 10'h000;
    end else if (in_tick) begin
      psc_reg <= psc_reg + 10'h001;
    end
  end

  assign top = (ctrl.wgm == `AET_WGM_CTC) ? compare_a_reg : `AET_COUNT_MAX;
  assign match_a = cnt_tick && !block_match_reg && count_reg == compare_a_reg;
  assign match_b = cnt_tick && !block_match_reg && count_reg == compare_b_reg;
  assign evt.match_a = match_a;
  assign evt.match_b = match_b;
  assign evt.overflow = cnt_tick && count_reg == `AET_COUNT_MAX;

  // cpu write beats counting; next tick sees no match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `AET_RESET_VALUE;
      block_match_reg <= 1'b0;
    end else if (apply[`AET_BUSY_COUNT]) begin
      count_reg <= apply_data[`AET_BUSY_COUNT];
      block_match_reg <= 1'b1;
    end else if (cnt_tick) begin
      count_reg <= (count_reg == top) ? 8'h00 : count_reg + 8'h01;
      block_match_reg <= 1'b0;
    end
  end

  // readable count follows external edges only in async mode, every clock otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_view_reg <= `AET_RESET_VALUE;
    end else if (!async_select_reg || ext_tick) begin
      count_view_reg <= count_reg;
    end
  end

  // outputs move on timer ticks or forced strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
      compare_output_a_oe <= 1'b0;
      compare_output_b_oe <= 1'b0;
    end else begin
      compare_output_a_oe <= ctrl.com_a != 2'h0;
      compare_output_b_oe <= ctrl.com_b != 2'h0;
      // force acts like a match on the pin only
      if (match_a || force_a_reg) begin
        compare_output_a <= wave_next(ctrl.com_a, compare_output_a);
      end
      if (match_b || force_b_reg) begin
        compare_output_b <= wave_next(ctrl.com_b, compare_output_b);
      end
    end
  end

  // wait for a timer edge, then three system clocks
  // flag, and so wake, lands after the next timer clock
  // pending event cleared only by a timer edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= '0;
      pipe0_reg <= '0;
      pipe1_reg <= '0;
      pipe2_reg <= '0;
    end else begin
      pend_reg <= ext_tick ? evt : (pend_reg | evt);
      pipe0_reg <= ext_tick ? pend_reg : '0;
      pipe1_reg <= pipe0_reg;
      pipe2_reg <= pipe1_reg;
    end
  end
  assign flag_set = async_select_reg ? pipe2_reg : evt;

  // write one clears; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flags_reg <= `AET_RESET_VALUE;
      irq_mask_reg <= `AET_RESET_VALUE;
      async_select_reg <= 1'b0;
      psc_clear_reg <= 1'b0;
      irq_request <= 1'b0;
      osc_enable <= 1'b0;
    end else begin
      if (wr_en && idx == `AET_IDX_IRQ_FLAGS) begin
        irq_flags_reg <= {5'h00, (irq_flags_reg[2:0] & ~wbyte[2:0]) | flag_set};
      end else begin
        irq_flags_reg <= {5'h00, irq_flags_reg[2:0] | flag_set};
      end
      if (wr_en && idx == `AET_IDX_IRQ_MASK) begin
        irq_mask_reg <= wbyte & 8'h07;
      end
      if (wr_en && idx == `AET_IDX_ASYNC_STATUS) begin
        async_select_reg <= wbyte[`AET_ASYNC_SELECT_BIT];
      end
      psc_clear_reg <= wr_en && idx == `AET_IDX_SPECIAL_FUNC && wbyte[`AET_PRESCALER_RESET_BIT];
      irq_request <= |(irq_flags_reg & irq_mask_reg);
      osc_enable <= async_select_reg & ~power_down_sleep;
    end
  end

  // busy bits readable in async status
  always_comb begin
    rdata = 8'h00;
    case (idx)
      `AET_IDX_IRQ_FLAGS: rdata = irq_flags_reg;
      `AET_IDX_IRQ_MASK: rdata = irq_mask_reg;
      `AET_IDX_CONTROL_A: rdata = control_a_reg;
      `AET_IDX_CONTROL_B: rdata = control_b_reg;
      `AET_IDX_COUNT: rdata = count_view_reg;
      `AET_IDX_COMPARE_A: rdata = compare_a_reg;
      `AET_IDX_COMPARE_B: rdata = compare_b_reg;
      `AET_IDX_ASYNC_STATUS: rdata = {2'b00, async_select_reg, busy_reg};
      `AET_IDX_SPECIAL_FUNC: rdata = 8'h00;
      default: rdata = 8'h00;
    endcase
  end

  // zero wait states: answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      if (rd_setup) begin
        prdata <= (pwrite || paddr[1:0] != 2'b00) ? 32'h0000_0000 : {24'h00_0000, rdata};
        pslverr <= paddr[1:0] != 2'b00 ||
                   !(idx == `AET_IDX_IRQ_FLAGS || idx == `AET_IDX_IRQ_MASK ||
                     (idx >= `AET_IDX_CONTROL_A && idx <= `AET_IDX_SPECIAL_FUNC &&
                      idx != 8'hB5));
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule : aet_timer
`default_nettype wire

// file: tb/aet_monitor.sv
// checker for bus timing, oscillator gating and pin relations of the timer
`timescale 1ns/1ps
`default_nettype none
`include "aet_defs.svh"
module aet_monitor
  import aet_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_osc_in,
  input wire logic power_down_sleep,
  input wire logic osc_enable,
  input wire logic compare_output_a,
  input wire logic compare_output_a_oe,
  input wire logic compare_output_b,
  input wire logic compare_output_b_oe,
  input wire logic irq_request
);
  logic wr_ok;
  logic as_reg;
  logic pin_reg;
  logic [3:0] gap_reg;
  logic [7:0] mask_reg;
  assign wr_ok = psel & penable & pready & pwrite & ~pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      as_reg <= 1'b0;
      mask_reg <= 8'h00;
    end else if (wr_ok && paddr == {`AET_IDX_ASYNC_STATUS, 2'b00}) begin
      as_reg <= pwdata[`AET_ASYNC_SELECT_BIT];
    end else if (wr_ok && paddr == {`AET_IDX_IRQ_MASK, 2'b00}) begin
      mask_reg <= pwdata[7:0];
    end
  end
  // cycles since the pin rose, saturating so it cannot wrap back under the bound
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
      gap_reg <= 4'h0;
    end else begin
      pin_reg <= ext_osc_in;
      gap_reg <= (ext_osc_in & ~pin_reg) ? 4'h0 : ((gap_reg == 4'hf) ? gap_reg : gap_reg + 4'h1);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready_setup; pready |-> $past(psel && !penable); endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("pready without setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready stood too long");
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  property p_misalign; psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr; endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
  property p_osc; osc_enable == $past(as_reg && !power_down_sleep); endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
  property p_oe_a; wr_ok && !as_reg && paddr == {`AET_IDX_CONTROL_A, 2'b00}
    |-> ##2 compare_output_a_oe == ($past(pwdata[7], 2) | $past(pwdata[6], 2)); endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin a enable wrong");
  property p_oe_b; wr_ok && !as_reg && paddr == {`AET_IDX_CONTROL_A, 2'b00}
    |-> ##2 compare_output_b_oe == ($past(pwdata[5], 2) | $past(pwdata[4], 2)); endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin b enable wrong");
  property p_timed; as_reg && ($changed(compare_output_a) || $changed(compare_output_b))
    |-> gap_reg <= 4'ha; endproperty
  a_timed: assert property (p_timed) else $error("output moved off timer edge");
  property p_masked; mask_reg == 8'h00 |=> !irq_request; endproperty
  a_masked: assert property (p_masked) else $error("request while masked");
endmodule : aet_monitor
bind aet_timer aet_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_osc_in(ext_osc_in), .power_down_sleep(power_down_sleep), .osc_enable(osc_enable),
  .compare_output_a(compare_output_a), .compare_output_a_oe(compare_output_a_oe),
  .compare_output_b(compare_output_b), .compare_output_b_oe(compare_output_b_oe),
  .irq_request(irq_request)
);
`default_nettype wire

// file: tb/aet_xtal_model.sv
// watch-crystal stand-in that drives the timer's oscillator pin
`timescale 1ns/1ps
`default_nettype none
module aet_xtal_model
  import aet_pkg::*;
#(
  parameter int half_ns = 163
) (
  input wire logic osc_enable,
  output logic ext_osc_in
);
  initial begin
    ext_osc_in = 1'b0;
  end
  // swings only while enabled
  // odd half period keeps it unrelated in phase to pclk
  always begin
    wait (osc_enable === 1'b1);
    #(half_ns) ext_osc_in = ~ext_osc_in;
  end
endmodule : aet_xtal_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the asynchronous eight-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "aet_defs.svh"
module tb
  import aet_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, ext_osc_in, power_down_sleep;
  logic pready, pslverr, osc_enable, oa, oa_oe, ob, ob_oe, irq_request, e;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] mis;
  logic [7:0] rv, a;
  int mismatches, samples_checked, w, lo, hi, c;
  time t0;
  int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] regs [8] = '{8'h37, 8'h70, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb6};
  localparam logic [7:0] i_ca = `AET_IDX_CONTROL_A;
  localparam logic [7:0] i_cb = `AET_IDX_CONTROL_B;
  localparam logic [7:0] i_cnt = `AET_IDX_COUNT;
  localparam logic [7:0] i_cma = `AET_IDX_COMPARE_A;
  localparam logic [7:0] i_as = `AET_IDX_ASYNC_STATUS;
  localparam logic [7:0] i_sf = `AET_IDX_SPECIAL_FUNC;
  always #10 pclk = ~pclk;
  aet_timer u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_osc_in(ext_osc_in), .power_down_sleep(power_down_sleep), .osc_enable(osc_enable),
    .compare_output_a(oa), .compare_output_a_oe(oa_oe), .compare_output_b(ob),
    .compare_output_b_oe(ob_oe), .irq_request(irq_request)
  );
  aet_xtal_model u_xtal (.osc_enable(osc_enable), .ext_osc_in(ext_osc_in));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] l, input logic [7:0] h);
    samples_checked++;
    if (((g >= l) && (g <= h)) !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h want %h..%h", $time, g, l, h);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic wn, input logic [7:0] i, input logic [7:0] d,
                      output logic [7:0] r, output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= wn;
    paddr <= {i, mis};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      give_verdict();
    end
    r = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic er;
    xfer(1'b1, i, d, rv, er);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] l, input logic [7:0] h);
    logic er;
    xfer(1'b0, i, 8'h00, rv, er);
    chk(rv, l, h);
  endtask : rd
  // poll the busy bits; a stuck bit ends the run
  task automatic idle;
    logic er;
    for (int k = 0; k < 200; k++) begin
      xfer(1'b0, i_as, 8'h00, rv, er);
      if ((rv & 8'h1f) === 8'h00) break;
    end
    if ((rv & 8'h1f) !== 8'h00) begin
      mismatches++;
      give_verdict();
    end
  endtask : idle
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
    power_down_sleep = 1'b0;
    mis = 2'b00;
    mismatches = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[k]) rd(regs[k], 8'h00, 8'h00);
    xfer(1'b0, 8'h00, 8'h00, rv, e);
    chk({7'h00, e}, 8'h01, 8'h01);
    mis = 2'b01;
    wr(`AET_IDX_COMPARE_B, 8'h5a);
    mis = 2'b00;
    rd(`AET_IDX_COMPARE_B, 8'h00, 8'h00);
    wr(i_ca, 8'h40);
    wr(i_cb, 8'h80);
    repeat (2) @(posedge pclk);
    chk({7'h00, oa}, 8'h01, 8'h01);
    rd(i_cb, 8'h00, 8'h00);
    rd(`AET_IDX_IRQ_FLAGS, 8'h00, 8'h00);
    wr(i_cma, 8'h03);
    wr(i_ca, 8'h02);
    wr(i_cb, 8'h01);
    repeat (6) rd(i_cnt, 8'h00, 8'h03);
    rd(`AET_IDX_IRQ_FLAGS, 8'h06, 8'h06);
    wr(`AET_IDX_IRQ_MASK, 8'h02);
    repeat (2) @(posedge pclk);
    chk({7'h00, irq_request}, 8'h01, 8'h01);
    wr(`AET_IDX_IRQ_MASK, 8'h00);
    wr(i_cb, 8'h09);
    repeat (20) @(posedge pclk);
    rd(i_cnt, 8'h08, 8'h40);
    wr(i_ca, 8'h00);
    for (int k = 0; k < 8; k++) begin
      w = (dv[k] < 2) ? 32 : 4 * dv[k] - 8;
      lo = (dv[k] == 0) ? 0 : ((dv[k] == 1) ? 30 : 2);
      hi = (dv[k] == 0) ? 0 : ((dv[k] == 1) ? 38 : 4);
      wr(i_cb, 8'(k));
      wr(i_sf, 8'h01);
      wr(i_cnt, 8'h00);
      repeat (w) @(posedge pclk);
      rd(i_cnt, 8'(lo), 8'(hi));
    end
    wr(i_sf, 8'h01);
    wr(i_cnt, 8'h00);
    repeat (1000) @(posedge pclk);
    rd(i_cnt, 8'h00, 8'h00);
    wr(i_cb, 8'h00);
    wr(i_cnt, 8'h00);
    wr(i_ca, 8'h40);
    wr(i_as, 8'h20);
    repeat (64) @(posedge pclk);
    wr(i_cnt, 8'h55);
    wr(i_cma, 8'h66);
    t0 = $time;
    rd(i_as, 8'h38, 8'h38);
    rd(i_cnt, 8'h00, 8'h00);
    idle();
    c = int'(($time - t0) / 20);
    chk(8'(c), 8'd15, 8'd42);
    repeat (40) @(posedge pclk);
    rd(i_cnt, 8'h55, 8'h55);
    rd(i_cma, 8'h66, 8'h66);
    rd(i_as, 8'h20, 8'h20);
    wr(i_cb, 8'h01);
    idle();
    wr(i_cma, 8'h66);
    idle();
    rd(i_cnt, 8'h55, 8'h60);
    a = rv;
    repeat (160) @(posedge pclk);
    rd(i_cnt, a + 8'h08, a + 8'h0b);
    wr(i_cb, 8'h81);
    idle();
    power_down_sleep <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(i_cnt, 8'h00, 8'hff);
    a = rv;
    repeat (100) @(posedge pclk);
    rd(i_cnt, a, a);
    chk({7'h00, osc_enable}, 8'h00, 8'h00);
    power_down_sleep <= 1'b0;
    repeat (40) @(posedge pclk);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
